/* test/data_eeprom_unlock_control_tb_top.sv */
`timescale 1ns/1ps
`include "eeuc_map.svh"
// ****
// Testbench
// ****
module data_eeprom_unlock_control_tb_top;
  localparam logic [1:0] sk = `EEUC_SEL_KEY, sc = `EEUC_SEL_CTRL, sa = `EEUC_SEL_ADDR;
  logic        core_clk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [1:0]  reg_sel;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        ee_rd;
  logic [23:0] ee_addr;
  logic [15:0] ee_rdata;
  logic        ee_hit;
  logic        op_busy;
  logic        op_done;
  int          error_cnt;
  int          n_tests;

  eeuc_ctrl dut (
    .core_clk  (core_clk),
    .rst       (rst),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_sel   (reg_sel),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .ee_rd     (ee_rd),
    .ee_addr   (ee_addr),
    .ee_rdata  (ee_rdata),
    .ee_hit    (ee_hit),
    .op_busy   (op_busy),
    .op_done   (op_done)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_sel   <= s;
    reg_wdata <= d;
  endtask

  task automatic idle(input int n);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [1:0] s);
    @(posedge core_clk);
    reg_wr  <= 1'b0;
    reg_sel <= s;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic t_map();
    logic [23:0] a [4] = '{24'h7F_FDFF, 24'h7F_FE00, 24'h7F_FFFF, 24'h80_0000};
    foreach (a[i])
    begin
      @(posedge core_clk);
      ee_addr <= a[i];
      #1;
      chk({15'h0, ee_hit}, 16'(i == 1 || i == 2));
    end
    $display("t_map done");
  endtask

  task automatic t_op(input logic [7:0] op, input logic [15:0] d, input logic [15:0] exp);
    int i;
    @(posedge core_clk);
    ee_addr <= 24'h7F_FE10;
    wr(sa, 16'hFE10);
    wr(`EEUC_SEL_DATA, d);
    wr(sk, 16'h0055);
    wr(sk, 16'h00AA);
    wr(sc, {8'hC0, op});
    idle(2);
    chk({15'h0, op_busy}, 16'h0001);
    rd(sa);
    chk(reg_rdata, 16'hFE10);
    chk({15'h0, op_busy}, 16'h0001);
    for (i = 0; i < 40 && op_done !== 1'b1; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk({15'h0, op_done}, 16'h0001);
    if (op_done !== 1'b1)
      stop_test();
    rd(sc);
    chk(reg_rdata & 16'hA000, 16'h0000);
    @(posedge core_clk);
    ee_rd <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(ee_rdata, exp);
    @(posedge core_clk);
    ee_rd <= 1'b0;
    $display("t_op %h done", op);
  endtask

  task automatic t_key_read();
    wr(sk, 16'h0055);
    rd(sk);
    chk(reg_rdata, 16'h0000);
    $display("t_key_read done");
  endtask

  task automatic t_reject(input logic [15:0] k2, input bit gap, input logic [15:0] ctl);
    wr(sc, 16'h0004);
    rd(sc);
    chk(reg_rdata & 16'h2000, 16'h0000);
    if (k2 != 16'h0000)
    begin
      wr(sk, 16'h0055);
      wr(sk, k2);
    end
    if (gap)
      idle(0);
    wr(sc, ctl);
    idle(3);
    chk({15'h0, op_busy}, 16'h0000);
    rd(sc);
    chk(reg_rdata & 16'hA000, 16'h2000);
    $display("t_reject %h done", k2);
  endtask

  initial
  begin
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_sel   = 2'h0;
    reg_wdata = 16'h0000;
    ee_rd     = 1'b0;
    ee_addr   = 24'h00_0000;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_map();
    t_key_read();
    t_op(`EEUC_OP_ERASE_WORD, 16'h0000, `EEUC_ERASED_WORD);
    t_op(`EEUC_OP_WRITE_WORD, 16'h1234, 16'h1234);
    t_reject(16'h0000, 1'b0, 16'hC004);
    t_reject(16'h0012, 1'b0, 16'hC004);
    t_reject(16'h00AA, 1'b1, 16'hC004);
    t_reject(16'h00AA, 1'b0, 16'h8004);
    stop_test();
  end
endmodule // data_eeprom_unlock_control_tb_top

/* test/eeuc_ctrl_chk.sv */
`timescale 1ns/1ps
`include "eeuc_map.svh"
// ****
// Port checker
// ****
module eeuc_ctrl_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [1:0]  reg_sel,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        ee_rd,
  input wire logic [23:0] ee_addr,
  input wire logic [15:0] ee_rdata,
  input wire logic        ee_hit,
  input wire logic        op_busy,
  input wire logic        op_done
);
  logic [4:0] busy_cnt_q;
  wire key = reg_wr && reg_sel == `EEUC_SEL_KEY;
  wire k55 = key && reg_wdata == 16'h0055;
  wire kaa = key && reg_wdata == 16'h00AA;
  wire go  = reg_wr && reg_sel == `EEUC_SEL_CTRL && reg_wdata[15:14] == 2'b11 && !op_busy;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk)
  begin
    if (rst || !op_busy)
      busy_cnt_q <= 5'h0;
    else
      busy_cnt_q <= busy_cnt_q + 5'h1;
  end
  a_hit_window: assert property (ee_hit == (ee_addr >= `EEUC_EE_BASE_ADDR && ee_addr <= `EEUC_EE_TOP_ADDR))
    else $error("hit flag wrong");
  a_key_reads_zero: assert property ($past(reg_sel) == `EEUC_SEL_KEY |-> reg_rdata == 16'h0000)
    else $error("key register readable");
  a_unlock_start: assert property (k55 ##1 kaa ##1 go |-> ##[2:3] op_busy)
    else $error("unlocked start lost");
  a_no_key_start: assert property (go && !$past(kaa) |=> !op_busy [*3])
    else $error("start without key");
  a_wrong_key: assert property (k55 ##1 key && !kaa && !k55 ##1 go |=> !op_busy [*3])
    else $error("start after wrong key");
  a_busy_length: assert property ($fell(op_busy) |-> busy_cnt_q == 5'h10)
    else $error("busy length wrong");
  a_done_timing: assert property ($rose(op_busy) |-> ##[12:20] op_done)
    else $error("done missing");
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("done not a pulse");
  c_start: cover property ($rose(op_busy));
  c_done: cover property (op_done);
  c_hit: cover property (ee_hit && ee_rd);
endmodule // eeuc_ctrl_chk

bind eeuc_ctrl eeuc_ctrl_chk u_chk (
  .core_clk  (core_clk),
  .rst       (rst),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_sel   (reg_sel),
  .reg_wdata (reg_wdata),
  .reg_rdata (reg_rdata),
  .ee_rd     (ee_rd),
  .ee_addr   (ee_addr),
  .ee_rdata  (ee_rdata),
  .ee_hit    (ee_hit),
  .op_busy   (op_busy),
  .op_done   (op_done)
);

/* verilog/eeuc_array.sv */
`timescale 1ns/1ps
`include "eeuc_map.svh"
module eeuc_array #(
  parameter int WORDS = `EEUC_EE_WORDS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  eeuc_array_if.arr        arr,
  input  wire logic [7:0]  rd_index,
  output logic [15:0]      rd_data
);
  import eeuc_pkg::*;

  // ****************************************
  // Word storage
  // ****************************************
  logic [15:0] mem_q [WORDS];
  logic [15:0] cnt_q;
  logic        busy_q;
  logic        done_q;
  logic        erase_q;
  logic [7:0]  idx_q;
  logic [15:0] data_q;

  assign arr.busy = busy_q;
  assign arr.done = done_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      cnt_q   <= 16'h0000;
      erase_q <= 1'b0;
      idx_q   <= 8'h00;
      data_q  <= 16'h0000;
    end
    else
    begin
      done_q <= 1'b0;
      if (!busy_q && arr.start)
      begin
        busy_q  <= 1'b1;
        cnt_q   <= `EEUC_OP_CYCLES;
        erase_q <= arr.erase;
        idx_q   <= arr.index;
        data_q  <= arr.wdata;
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q - 16'h0001;
        if (cnt_q == 16'h0001)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  // Word update at end of operation
  always_ff @(posedge core_clk)
  begin
    if (busy_q && cnt_q == 16'h0001)
      mem_q[idx_q] <= erase_q ? `EEUC_ERASED_WORD : data_q;
  end

  always_ff @(posedge core_clk)
  begin
    rd_data <= mem_q[rd_index];
  end
endmodule // eeuc_array

/* verilog/eeuc_array_if.sv */
`timescale 1ns/1ps
interface eeuc_array_if;
  logic        start;
  logic        erase;
  logic [7:0]  index;
  logic [15:0] wdata;
  logic        busy;
  logic        done;
  modport ctrl (output start, output erase, output index, output wdata, input busy, input done);
  modport arr  (input start, input erase, input index, input wdata, output busy, output done);
endinterface

/* verilog/eeuc_ctrl.sv */
`timescale 1ns/1ps
`include "eeuc_map.svh"
// Contract
// - The EEPROM occupies program addresses 7FFE00h through 7FFFFFh.
// - The EEPROM holds 256 words.
// - Each EEPROM word is 16 bits and individually addressable.
// - Words may be read and written in normal operation.
// - The CPU keeps running while a program or erase is in progress.
// - Programming is controlled by operation control, unlock key and address registers.
// - The upper control byte holds the start bits and the error flag.
// - The lower control byte selects the kind of operation.
// - The unlock key register is write-only and only guards against accidental writes.
// - After a correct key pair, a control write is accepted only in the next cycle.
// - Setting start with enable within the unlock window begins the selected operation.
module eeuc_ctrl (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [1:0]  reg_sel,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  input  wire logic        ee_rd,
  input  wire logic [23:0] ee_addr,
  output logic [15:0]      ee_rdata,
  output logic             ee_hit,
  output logic             op_busy,
  output logic             op_done
);
  import eeuc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  eeuc_key_state_type key_q;
  logic        window_q;
  logic [15:0] ctrl_q;
  logic [15:0] data_latch_q;
  logic [23:0] addr_q;
  logic [15:0] arr_rdata;
  logic [7:0]  rd_index;
  logic        ctrl_wr;
  logic        start_req;
  logic        busy_q1;
  eeuc_array_if arr_bus ();

  // Unused read strobe kept for bus symmetry
  logic unused_rd;
  assign unused_rd = reg_rd;

  // ****************************************
  // Address decode of EEPROM window
  // ****************************************
  assign ee_hit   = (ee_addr >= `EEUC_EE_BASE_ADDR) && (ee_addr <= `EEUC_EE_TOP_ADDR);
  assign rd_index = ee_addr[`EEUC_EE_IDX_MSB:`EEUC_EE_IDX_LSB];

  // ****************************************
  // Key sequence
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      key_q    <= EEUC_IDLE;
      window_q <= 1'b0;
    end
    else
    begin
      window_q <= 1'b0;
      case (key_q)
        EEUC_IDLE:
        begin
          if (reg_wr && reg_sel == `EEUC_SEL_KEY && reg_wdata[7:0] == `EEUC_KEY_FIRST)
            key_q <= EEUC_GOT_FIRST;
        end
        EEUC_GOT_FIRST:
        begin
          if (reg_wr)
          begin
            key_q <= EEUC_IDLE;
            if (reg_sel == `EEUC_SEL_KEY && reg_wdata[7:0] == `EEUC_KEY_SECOND)
              window_q <= 1'b1;
            else if (reg_sel == `EEUC_SEL_KEY && reg_wdata[7:0] == `EEUC_KEY_FIRST)
              key_q <= EEUC_GOT_FIRST;
          end
        end
        default:
          key_q <= EEUC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Operation control register
  // ****************************************
  assign ctrl_wr   = reg_wr && reg_sel == `EEUC_SEL_CTRL;
  assign start_req = ctrl_wr && window_q && reg_wdata[`EEUC_CTRL_START_BIT] && !ctrl_q[`EEUC_CTRL_START_BIT];

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_q <= `EEUC_CTRL_RESET;
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_q[`EEUC_CTRL_OP_MSB:`EEUC_CTRL_OP_LSB] <= reg_wdata[`EEUC_CTRL_OP_MSB:`EEUC_CTRL_OP_LSB];
        ctrl_q[`EEUC_CTRL_ENABLE_BIT] <= reg_wdata[`EEUC_CTRL_ENABLE_BIT];
        if (!reg_wdata[`EEUC_CTRL_ERROR_BIT])
          ctrl_q[`EEUC_CTRL_ERROR_BIT] <= 1'b0;
      end
      if (start_req)
      begin
        if (reg_wdata[`EEUC_CTRL_ENABLE_BIT])
          ctrl_q[`EEUC_CTRL_START_BIT] <= 1'b1;
        else
          ctrl_q[`EEUC_CTRL_ERROR_BIT] <= 1'b1;
      end
      else if (ctrl_wr && !window_q && reg_wdata[`EEUC_CTRL_START_BIT])
        ctrl_q[`EEUC_CTRL_ERROR_BIT] <= 1'b1;
      if (arr_bus.done)
        ctrl_q[`EEUC_CTRL_START_BIT] <= 1'b0;
    end
  end

  // ****************************************
  // Address and data latches
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      addr_q       <= `EEUC_EE_BASE_ADDR;
      data_latch_q <= `EEUC_ERASED_WORD;
    end
    else
    begin
      if (reg_wr && reg_sel == `EEUC_SEL_ADDR)
        addr_q <= {8'h00, reg_wdata};
      if (ee_hit && reg_wr && reg_sel == `EEUC_SEL_DATA)
        data_latch_q <= reg_wdata;
    end
  end

  // ****************************************
  // Array launch, CPU not stalled
  // ****************************************
  assign arr_bus.start = start_req && reg_wdata[`EEUC_CTRL_ENABLE_BIT];
  assign arr_bus.erase = reg_wdata[`EEUC_CTRL_OP_MSB:`EEUC_CTRL_OP_LSB] == `EEUC_OP_ERASE_WORD;
  assign arr_bus.index = addr_q[`EEUC_EE_IDX_MSB:`EEUC_EE_IDX_LSB];
  assign arr_bus.wdata = data_latch_q;

  eeuc_array u_array (
    .core_clk (core_clk),
    .rst      (rst),
    .arr      (arr_bus),
    .rd_index (rd_index),
    .rd_data  (arr_rdata)
  );

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busy_q1 <= 1'b0;
      op_done <= 1'b0;
    end
    else
    begin
      busy_q1 <= arr_bus.busy;
      op_done <= arr_bus.done;
    end
  end
  assign op_busy = busy_q1;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ee_rdata <= 16'h0000;
    else if (ee_rd)
      ee_rdata <= arr_rdata;
  end

  // Key register reads as zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else
      case (reg_sel)
        `EEUC_SEL_CTRL: reg_rdata <= ctrl_q;
        `EEUC_SEL_KEY:  reg_rdata <= 16'h0000;
        `EEUC_SEL_ADDR: reg_rdata <= addr_q[15:0];
        default:        reg_rdata <= 16'h0000;
      endcase
  end
endmodule // eeuc_ctrl

/* verilog/eeuc_map.svh */
`ifndef EEUC_MAP_SVH
`define EEUC_MAP_SVH

// Word address window of the data EEPROM in program space
`define EEUC_EE_BASE_ADDR   24'h7F_FE00
`define EEUC_EE_TOP_ADDR    24'h7F_FFFF
`define EEUC_EE_WORDS       256
`define EEUC_EE_IDX_LSB     1
`define EEUC_EE_IDX_MSB     8

// Register selects on the peripheral bus
`define EEUC_SEL_CTRL       2'h0
`define EEUC_SEL_KEY        2'h1
`define EEUC_SEL_ADDR       2'h2
`define EEUC_SEL_DATA       2'h3

// Unlock key values
`define EEUC_KEY_FIRST      8'h55
`define EEUC_KEY_SECOND     8'hAA

// Operation control fields
`define EEUC_CTRL_START_BIT 15
`define EEUC_CTRL_ENABLE_BIT 14
`define EEUC_CTRL_ERROR_BIT 13
`define EEUC_CTRL_OP_MSB    7
`define EEUC_CTRL_OP_LSB    0
`define EEUC_CTRL_RESET     16'h0000

// Operation codes in the lower control byte
`define EEUC_OP_ERASE_WORD  8'h58
`define EEUC_OP_WRITE_WORD  8'h04

// Cycles a program or erase takes in the array model
`define EEUC_OP_CYCLES      16'h0010
`define EEUC_ERASED_WORD    16'hFFFF

`endif

/* verilog/eeuc_pkg.sv */
package eeuc_pkg;
  typedef enum logic [1:0] {EEUC_IDLE, EEUC_GOT_FIRST} eeuc_key_state_type;
  typedef enum logic [1:0] {EEUC_OP_IDLE, EEUC_OP_BUSY} eeuc_op_state_type;
endpackage
